// ==== gate_drive_fault_gating.sv ====
// Operation
// - gate pulses are blocked while failsafeEnableN is low and pass again once it is high.
// - while the configuration-mode bit is 1 gate pulses are suppressed until the host writes it to 0.
// - a gate voltage monitor fault sets the gate voltage fault flag and locks out the gate.
// - the gate voltage fault stays set until cleared and a mask bit of 0 stops it acting.
// - a short circuit sets a latched fault that disables pulses, cannot be masked, and holds until cleared.
// - the short-circuit detector uses a software threshold and filter time.
// - an overcurrent sets a latched unmaskable flag while pulses keep running.
// - the overcurrent detector uses a software threshold and filter time.
// - dead time is always inserted and an input overlap sets a latched clearable dead-time fault.
// - the dead-time length comes from a software field and its fault can be masked.
// - if one die powers up before the other a latched watchdog fault is reported until cleared.
// - an open serial bus or undriven chip select at start-up sets the serial error flag until cleared.
// - a serial frame whose clock count is not a multiple of 24 sets the serial error flag.
// - a chip select gap shorter than the minimum sets the serial error flag.
`timescale 1ns/1ps
`default_nettype none
`include "gate_drive_cfg.svh"
module gate_drive_fault_gating (
	input wire logic clk,
	input wire logic rstn,
	input wire logic highSideDriveIn,
	input wire logic lowSideDriveIn,
	input wire logic failsafeEnableN,
	input wire logic modeControlWrite,
	input wire logic modeControlValue,
	input wire logic gateVoltageFaultMask,
	input wire logic deadtimeFaultMask,
	input wire logic [`DT_W-1:0] deadtimeConfig,
	input wire gate_drive_pkg::detect_cfg_s overcurrentConfig,
	input wire gate_drive_pkg::detect_cfg_s shortCircuitConfig,
	input wire logic [`THR_W-1:0] currentSense,
	input wire logic gateVoltageMonitor,
	input wire logic dieLinkLate,
	input wire logic serialBusOpen,
	input wire logic chipSelectN,
	input wire logic serialClk,
	input wire gate_drive_pkg::fault_s faultClear,
	output logic highSideGate,
	output logic lowSideGate,
	output logic modeControlBit,
	output gate_drive_pkg::fault_s faultStatus
);
	import gate_drive_pkg::*;

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic hsF, lsF, fsF, gvF, csF, scF, dlF, boF;
	gate_drive_pin_sync hsSync_u (
		.clk(clk),
		.rstn(rstn),
		.pinIn(highSideDriveIn),
		.level(hsF)
	);
	gate_drive_pin_sync lsSync_u (
		.clk(clk),
		.rstn(rstn),
		.pinIn(lowSideDriveIn),
		.level(lsF)
	);
	gate_drive_pin_sync fsSync_u (
		.clk(clk),
		.rstn(rstn),
		.pinIn(failsafeEnableN),
		.level(fsF)
	);
	gate_drive_pin_sync gvSync_u (
		.clk(clk),
		.rstn(rstn),
		.pinIn(gateVoltageMonitor),
		.level(gvF)
	);
	// chip select idles high, so its stages start high and no false edge follows reset
	gate_drive_pin_sync #(
		.RESET_LEVEL(`CS_IDLE_RST)
	) csSync_u (
		.clk(clk),
		.rstn(rstn),
		.pinIn(chipSelectN),
		.level(csF)
	);
	gate_drive_pin_sync scSync_u (
		.clk(clk),
		.rstn(rstn),
		.pinIn(serialClk),
		.level(scF)
	);
	gate_drive_pin_sync dlSync_u (
		.clk(clk),
		.rstn(rstn),
		.pinIn(dieLinkLate),
		.level(dlF)
	);
	gate_drive_pin_sync boSync_u (
		.clk(clk),
		.rstn(rstn),
		.pinIn(serialBusOpen),
		.level(boF)
	);

	// ****************************************
	// configuration mode
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rstn) modeControlBit <= `CFG_MODE_RST;
		else if (modeControlWrite) modeControlBit <= modeControlValue;
	end

	// ****************************************
	// current detectors with filter
	// ****************************************
	logic [`FILT_W-1:0] ocCnt_q, scCnt_q;
	logic ocHit, scHit;
	assign ocHit = (ocCnt_q >= overcurrentConfig.filter) && (currentSense >= overcurrentConfig.threshold);
	assign scHit = (scCnt_q >= shortCircuitConfig.filter) && (currentSense >= shortCircuitConfig.threshold);
	always_ff @(posedge clk) begin
		if (!rstn) ocCnt_q <= '0;
		else if (currentSense < overcurrentConfig.threshold) ocCnt_q <= '0;
		else if (ocCnt_q != {`FILT_W{1'b1}}) ocCnt_q <= ocCnt_q + 1'b1;
	end
	always_ff @(posedge clk) begin
		if (!rstn) scCnt_q <= '0;
		else if (currentSense < shortCircuitConfig.threshold) scCnt_q <= '0;
		else if (scCnt_q != {`FILT_W{1'b1}}) scCnt_q <= scCnt_q + 1'b1;
	end

	// ****************************************
	// serial supervision
	// ****************************************
	logic scPrev_q, csPrev_q, gapShort_q, frameErr, gapErr, initSerErr;
	logic [4:0] bitCnt_q;
	logic [$clog2(`CS_GAP_CYCLES+1)-1:0] gapCnt_q;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			scPrev_q <= 1'b0;
			csPrev_q <= 1'b1;
		end else begin
			scPrev_q <= scF;
			csPrev_q <= csF;
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) bitCnt_q <= '0;
		else if (csF && !csPrev_q) bitCnt_q <= '0;
		else if (!csF && scF && !scPrev_q) begin
			if (bitCnt_q == 5'(`FRAME_BITS - 1)) bitCnt_q <= '0;
			else bitCnt_q <= bitCnt_q + 1'b1;
		end
	end
	assign frameErr = csF && !csPrev_q && (bitCnt_q != '0);
	always_ff @(posedge clk) begin
		if (!rstn) begin
			gapCnt_q <= '0;
			gapShort_q <= 1'b0;
		end else if (csF && !csPrev_q) begin
			gapCnt_q <= '0;
			gapShort_q <= 1'b1;
		end else if (gapShort_q) begin
			if (gapCnt_q == ($bits(gapCnt_q))'(`CS_GAP_CYCLES - 1)) gapShort_q <= 1'b0;
			else gapCnt_q <= gapCnt_q + 1'b1;
		end
	end
	assign gapErr = !csF && csPrev_q && gapShort_q;
	// start-up check waits until the filtered levels carry the real pins, not their reset values
	logic [2:0] settleCnt_q;
	logic initPulse_q;
	always_ff @(posedge clk) begin
		if (!rstn) settleCnt_q <= '0;
		else if (settleCnt_q != 3'(`INIT_SETTLE_CYCLES)) settleCnt_q <= settleCnt_q + 1'b1;
	end
	always_ff @(posedge clk) begin
		if (!rstn) initPulse_q <= 1'b0;
		else initPulse_q <= (settleCnt_q == 3'(`INIT_SETTLE_CYCLES - 1));
	end
	assign initSerErr = initPulse_q && (boF || !csF);

	// ****************************************
	// latched faults, set wins over clear
	// ****************************************
	logic gvFlag, scFlag, ocFlag, dtFlag, dlFlag, seFlag;
	gate_drive_sticky_flag gvFlag_u (
		.clk(clk),
		.rstn(rstn),
		.setIn(gvF),
		.clearIn(faultClear.gateVoltage),
		.flag(gvFlag)
	);
	gate_drive_sticky_flag scFlag_u (
		.clk(clk),
		.rstn(rstn),
		.setIn(scHit),
		.clearIn(faultClear.shortCircuit),
		.flag(scFlag)
	);
	gate_drive_sticky_flag ocFlag_u (
		.clk(clk),
		.rstn(rstn),
		.setIn(ocHit),
		.clearIn(faultClear.overcurrent),
		.flag(ocFlag)
	);
	gate_drive_sticky_flag dtFlag_u (
		.clk(clk),
		.rstn(rstn),
		.setIn(hsF & lsF),
		.clearIn(faultClear.deadtime),
		.flag(dtFlag)
	);
	gate_drive_sticky_flag dlFlag_u (
		.clk(clk),
		.rstn(rstn),
		.setIn(initPulse_q & dlF),
		.clearIn(faultClear.dieLink),
		.flag(dlFlag)
	);
	gate_drive_sticky_flag seFlag_u (
		.clk(clk),
		.rstn(rstn),
		.setIn(initSerErr | frameErr | gapErr),
		.clearIn(faultClear.serialError),
		.flag(seFlag)
	);
	assign faultStatus = fault_s'({gvFlag, scFlag, ocFlag, dtFlag, dlFlag, seFlag});

	// ****************************************
	// dead time and gating
	// ****************************************
	phase_e phase_q;
	logic [`DT_W-1:0] dtCnt_q;
	logic allow;
	// overcurrent deliberately absent: it never blocks pulses
	assign allow = fsF && !modeControlBit && !faultStatus.shortCircuit
		&& !(faultStatus.gateVoltage && gateVoltageFaultMask)
		&& !(faultStatus.deadtime && deadtimeFaultMask);
	// an output may switch on only after dead time with both sides off
	always_ff @(posedge clk) begin
		if (!rstn) begin
			phase_q <= PH_IDLE;
			dtCnt_q <= '0;
		end else begin
			unique case (phase_q)
				PH_IDLE: begin
					if (dtCnt_q < deadtimeConfig) dtCnt_q <= dtCnt_q + 1'b1;
					else if (allow && hsF && !lsF) phase_q <= PH_HIGH;
					else if (allow && lsF && !hsF) phase_q <= PH_LOW;
				end
				PH_HIGH: if (!(allow && hsF && !lsF)) begin
					phase_q <= PH_IDLE;
					dtCnt_q <= '0;
				end
				PH_LOW: if (!(allow && lsF && !hsF)) begin
					phase_q <= PH_IDLE;
					dtCnt_q <= '0;
				end
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			highSideGate <= 1'b0;
			lowSideGate <= 1'b0;
		end else begin
			highSideGate <= (phase_q == PH_HIGH) && allow && hsF && !lsF;
			lowSideGate <= (phase_q == PH_LOW) && allow && lsF && !hsF;
		end
	end
endmodule : gate_drive_fault_gating

// ****************************************
// three-stage pin synchroniser
// ****************************************
module gate_drive_pin_sync #(
	parameter logic RESET_LEVEL = 1'b0
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic pinIn,
	output logic level
);
	logic [2:0] stage_q;
	// a new level counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (!rstn) stage_q <= {3{RESET_LEVEL}};
		else stage_q <= {stage_q[1:0], pinIn};
	end
	always_ff @(posedge clk) begin
		if (!rstn) level <= RESET_LEVEL;
		else if (stage_q[1] == stage_q[2]) level <= stage_q[2];
	end
endmodule : gate_drive_pin_sync

// ****************************************
// sticky fault flag, a set in the clear cycle wins
// ****************************************
module gate_drive_sticky_flag (
	input wire logic clk,
	input wire logic rstn,
	input wire logic setIn,
	input wire logic clearIn,
	output logic flag
);
	always_ff @(posedge clk) begin
		if (!rstn) flag <= 1'b0;
		else flag <= setIn | (flag & ~clearIn);
	end
endmodule : gate_drive_sticky_flag
`default_nettype wire

// ==== gate_drive_cfg.svh ====
`ifndef GATE_DRIVE_CFG_SVH
`define GATE_DRIVE_CFG_SVH
`define CLK_PERIOD_NS 10
`define FRAME_BITS 24
`define CS_GAP_MIN_NS 19000
`define CS_GAP_CYCLES ((`CS_GAP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DT_W 8
`define FILT_W 8
`define THR_W 8
`define CFG_MODE_RST 1'b1
`define GV_MASK_RST 1'b1
`define DT_MASK_RST 1'b1
`define INIT_SETTLE_CYCLES 4
`define CS_IDLE_RST 1'b1
`endif

// ==== gate_drive_pkg.sv ====
`default_nettype none
`include "gate_drive_cfg.svh"
package gate_drive_pkg;
	typedef struct packed {
		logic [`THR_W-1:0] threshold;
		logic [`FILT_W-1:0] filter;
	} detect_cfg_s;
	typedef struct packed {
		logic gateVoltage;
		logic shortCircuit;
		logic overcurrent;
		logic deadtime;
		logic dieLink;
		logic serialError;
	} fault_s;
	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_HIGH = 3'b010,
		PH_LOW = 3'b100
	} phase_e;
endpackage : gate_drive_pkg
`default_nettype wire

// ==== gate_drive_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// serial host
// ********
module gate_drive_host_model (
	input wire logic clk,
	output logic chipSelectN,
	output logic serialClk
);
	// deselected and clock parked low between frames
	initial begin
		chipSelectN = 1'b1;
		serialClk = 1'b0;
	end
	// n clock rises, five cycles per half period
	task automatic frame(input int n);
		@(negedge clk) chipSelectN <= 1'b0;
		repeat (2 * n) begin
			repeat (5) @(negedge clk);
			serialClk <= ~serialClk;
		end
		repeat (5) @(negedge clk);
		chipSelectN <= 1'b1;
	endtask : frame
endmodule : gate_drive_host_model
`default_nettype wire

// ==== gate_drive_fault_gating_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gate_drive_cfg.svh"
// ********
// gating checker
// ********
module gate_drive_fault_gating_props (
	input wire logic clk,
	input wire logic rstn,
	input wire logic failsafeEnableN,
	input wire logic gateVoltageMonitor,
	input wire logic gateVoltageFaultMask,
	input wire logic [`DT_W-1:0] deadtimeConfig,
	input wire gate_drive_pkg::fault_s faultClear,
	input wire logic highSideGate,
	input wire logic lowSideGate,
	input wire logic modeControlBit,
	input wire gate_drive_pkg::fault_s faultStatus
);
	import gate_drive_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	property p_fs; (!failsafeEnableN)[*8] |-> !highSideGate && !lowSideGate; endproperty
	a_fs: assert property (p_fs) else $error("gate on, failsafe low");
	property p_md; modeControlBit[*3] |-> !highSideGate && !lowSideGate; endproperty
	a_md: assert property (p_md) else $error("gate on in config mode");
	property p_gv; (gateVoltageMonitor && gateVoltageFaultMask)[*8] |-> faultStatus.gateVoltage; endproperty
	a_gv: assert property (p_gv) else $error("gate fault not set");
	property p_gvh; faultStatus.gateVoltage && !faultClear.gateVoltage |=> faultStatus.gateVoltage; endproperty
	a_gvh: assert property (p_gvh) else $error("gate fault lost");
	property p_sc; faultStatus.shortCircuit[*3] |-> !highSideGate && !lowSideGate; endproperty
	a_sc: assert property (p_sc) else $error("gate on, short fault");
	property p_och; faultStatus.overcurrent && !faultClear.overcurrent |=> faultStatus.overcurrent; endproperty
	a_och: assert property (p_och) else $error("overcurrent lost");
	property p_ov; !(highSideGate && lowSideGate); endproperty
	a_ov: assert property (p_ov) else $error("both gates on");
	property p_dt; $fell(highSideGate) && deadtimeConfig > 1 |=> !lowSideGate[*2]; endproperty
	a_dt: assert property (p_dt) else $error("dead time short");
endmodule : gate_drive_fault_gating_props
bind gate_drive_fault_gating gate_drive_fault_gating_props chk_u (.clk, .rstn, .failsafeEnableN, .gateVoltageMonitor,
	.gateVoltageFaultMask, .deadtimeConfig, .faultClear, .highSideGate, .lowSideGate, .modeControlBit, .faultStatus);
`default_nettype wire

// ==== gate_drive_fault_gating_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gate_drive_cfg.svh"
// ********
// gating bench
// ********
module gate_drive_fault_gating_tb_top;
	import gate_drive_pkg::*;
	logic clk, rstn, fsN, mw, mv, gvMask, dtMask, gvMon, dieLate, busOpen, csN, sClk, modeBit;
	logic [1:0] pwm, gate;
	logic [`DT_W-1:0] dtCfg;
	logic [`THR_W-1:0] sense;
	detect_cfg_s ocCfg, scCfg;
	fault_s clr, st;
	int miscompares, nCompared, w, g;
	int lens[4] = '{24, 48, 23, 24};
	int gaps[4] = '{2000, 2000, 2000, 20};
	gate_drive_fault_gating dut_u (.clk, .rstn, .highSideDriveIn(pwm[1]), .lowSideDriveIn(pwm[0]),
		.failsafeEnableN(fsN), .modeControlWrite(mw), .modeControlValue(mv), .gateVoltageFaultMask(gvMask),
		.deadtimeFaultMask(dtMask), .deadtimeConfig(dtCfg), .overcurrentConfig(ocCfg), .shortCircuitConfig(scCfg),
		.currentSense(sense), .gateVoltageMonitor(gvMon), .dieLinkLate(dieLate), .serialBusOpen(busOpen),
		.chipSelectN(csN), .serialClk(sClk), .faultClear(clr), .highSideGate(gate[1]), .lowSideGate(gate[0]),
		.modeControlBit(modeBit), .faultStatus(st));
	gate_drive_host_model host_u (.clk, .chipSelectN(csN), .serialClk(sClk));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nCompared++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic clear(input fault_s m);
		clr = m;
		cyc(1);
		clr = '0;
		cyc(2);
	endtask : clear
	task automatic complete_run();
		$display("compared %0d mismatches %0d", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	initial begin
		#200_000;
		miscompares++;
		complete_run();
	end
	initial begin
		{rstn, pwm, mw, mv, gvMon, clr, sense} = '0;
		{fsN, gvMask, dtMask, dieLate, busOpen} = '1;
		dtCfg = 8'h04;
		ocCfg = 16'h4004;
		scCfg = 16'hC004;
		cyc(16);
		rstn = 1'b1;
		cyc(8);
		chk({st, modeBit}, 8'h07);
		{dieLate, busOpen} = 2'b00;
		clear(6'h03);
		chk(st, 8'h00);
		$display("test startup done");
		pwm = 2'b10;
		cyc(12);
		chk(gate, 8'h00);
		mw = 1'b1;
		cyc(1);
		mw = 1'b0;
		cyc(12);
		chk({modeBit, gate}, 8'h02);
		fsN = 1'b0;
		cyc(12);
		chk(gate, 8'h00);
		fsN = 1'b1;
		cyc(12);
		chk(gate, 8'h02);
		{mw, mv} = 2'b11;
		cyc(1);
		mw = 1'b0;
		cyc(12);
		chk({modeBit, gate}, 8'h04);
		{mw, mv} = 2'b10;
		cyc(1);
		mw = 1'b0;
		cyc(12);
		chk({modeBit, gate}, 8'h02);
		$display("test gating done");
		gvMon = 1'b1;
		cyc(12);
		gvMon = 1'b0;
		cyc(12);
		chk({st, gate}, 8'h80);
		gvMask = 1'b0;
		cyc(12);
		chk({st, gate}, 8'h82);
		clear(6'h20);
		gvMask = 1'b1;
		sense = 8'hFF;
		cyc(2);
		sense = 8'h3F;
		cyc(12);
		chk({st, gate}, 8'h02);
		sense = 8'h40;
		cyc(12);
		chk({st, gate}, 8'h22);
		sense = 8'hC0;
		cyc(12);
		sense = 8'h00;
		{gvMask, dtMask} = 2'b00;
		cyc(12);
		chk({st, gate}, 8'h60);
		clear(6'h18);
		{gvMask, dtMask} = 2'b10;
		cyc(12);
		chk({st, gate}, 8'h02);
		$display("test faults done");
		// direct swaps may flag a violation, so the flag is masked here
		for (int d = 2; d < 12; d += 7) begin
			dtCfg = 8'(d);
			pwm = 2'b10;
			cyc(24);
			pwm = 2'b01;
			for (w = 0; w < 20 && gate[1] !== 1'b0; w++)
				cyc(1);
			for (g = 0; g < 40 && gate[0] !== 1'b1; g++)
				cyc(1);
			chk(g >= d && g <= d + 2, 8'h01);
		end
		clear(6'h04);
		dtMask = 1'b1;
		pwm = 2'b11;
		cyc(24);
		chk({st, gate}, 8'h10);
		pwm = 2'b10;
		cyc(24);
		chk(gate, 8'h00);
		dtMask = 1'b0;
		cyc(24);
		chk({st, gate}, 8'h12);
		clear(6'h04);
		dtMask = 1'b1;
		chk(st, 8'h00);
		$display("test deadtime done");
		foreach (lens[i]) begin
			cyc(gaps[i]);
			host_u.frame(lens[i]);
			cyc(8);
			chk(st.serialError, lens[i] % 24 != 0 || gaps[i] < `CS_GAP_CYCLES);
			clear(6'h01);
		end
		$display("test serial done");
		complete_run();
	end
endmodule : gate_drive_fault_gating_tb_top
`default_nettype wire
